// ===== shared/lcbdec_params.svh
// constants for the literal, control and bit-test decoder
`ifndef LCBDEC_PARAMS_SVH
`define LCBDEC_PARAMS_SVH

// instruction word fields
`define LCB_IW 12
`define LCB_FA_MSB 4
`define LCB_B_MSB 7
`define LCB_B_LSB 5
`define LCB_D_BIT 5
`define LCB_K_MSB 7
`define LCB_PFX_MSB 11
`define LCB_PFX_LSB 8
`define LCB_P6_LSB 6
`define LCB_P3_LSB 9
`define LCB_TF_MSB 2
`define LCB_NIB_MSB 3
`define LCB_HI9_LSB 3

// opcode prefixes (top four bits unless noted)
`define LCB_PFX_BCLR 4'h4
`define LCB_PFX_SKC 4'h6
`define LCB_PFX_SKS 4'h7
`define LCB_PFX_RETL 4'h8
`define LCB_PFX_CALL 4'h9
`define LCB_PFX_MOVL 4'hC
`define LCB_PFX_ORL 4'hD
`define LCB_PFX_ANDL 4'hE
`define LCB_PFX_XORL 4'hF
`define LCB_PFX_GOTO 3'h5
`define LCB_PFX_ADD 6'h07

// whole control words, then the direction-load top nine bits and port field
`define LCB_W_OPTION 12'h002
`define LCB_W_SLEEP 12'h003
`define LCB_W_WATCHDOG_CLEAR_OP 12'h004
`define LCB_PIN_DIRECTION_LOAD_HI 9'h000
`define LCB_PIN_DIRECTION_LOAD_PORT 3'h6

// register file addresses
`define LCB_ADDR_TIMER 5'h01
`define LCB_ADDR_PORT 5'h06

// option register: prescaler assignment bit, one = watchdog
`define LCB_OPT_PSA 3

// program counter
`define LCB_PCW 9
`define LCB_PC_HI 8

// reset values
`define LCB_RST_ACC 8'h00
`define LCB_RST_DIR 8'hFF
`define LCB_RST_OPT 8'hFF
`define LCB_RST_TO 1'b1
`define LCB_RST_PD 1'b1
`define LCB_ZERO8 8'h00

`endif

// ===== shared/lcbdec_pkg.sv
// types shared by the decoder
`default_nettype none
package lcbdec_pkg;
	// sequencer: normal execution or discarding the prefetched word
	typedef enum logic [1:0] {
		LCB_ST_EXEC = 2'b01,
		LCB_ST_FLUSH = 2'b10
	} lcbdec_state_t;

	// decoded operation
	typedef enum logic [3:0] {
		LCB_OP_NOP,
		LCB_OP_SKC,
		LCB_OP_SKS,
		LCB_OP_ANDL,
		LCB_OP_ORL,
		LCB_OP_MOVL,
		LCB_OP_XORL,
		LCB_OP_RETL,
		LCB_OP_CALL,
		LCB_OP_GOTO,
		LCB_OP_SLEEP,
		LCB_OP_WATCHDOG_CLEAR_OP,
		LCB_OP_PIN_DIRECTION_LOAD,
		LCB_OP_OPTION,
		LCB_OP_ADD,
		LCB_OP_BCLR
	} lcbdec_op_t;
endpackage
`default_nettype wire

// ===== hw/lcbdec_core.sv
// instruction decoder for the literal, control and bit-test group
`timescale 1ns/100ps
`default_nettype none
`include "lcbdec_params.svh"
// How it works
// - prefix 0110 skips next when bit zero
// - prefix 0111 skips next when bit one
// - skip discards fetched word, runs no-op
// - and, or, load literal; logic sets zero
// - xor literal into accumulator, sets zero
// - return loads literal, two cycles, no flags
// - call, jump two cycles; call clears bit eight
// - standby and watchdog clear set status
// - direction load from accumulator; option load
// - port self-modify reads pin levels
// - timer target clears assigned prescaler
// - add register, dest bit picks target
// - bit clear forces bit zero, no flags
module lcbdec_core
	import lcbdec_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// instruction stream
	input wire logic [`LCB_IW-1:0] instr,
	input wire logic instr_valid,
	// register file and pins
	output logic [`LCB_FA_MSB:0] reg_raddr,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pin_levels,
	output logic reg_wr,
	output logic [`LCB_FA_MSB:0] reg_waddr,
	output logic [7:0] reg_wdata,
	// program counter and stack
	input wire logic [`LCB_PCW-1:0] ret_addr,
	output logic pc_load,
	output logic [`LCB_PCW-1:0] pc_target,
	output logic stack_push,
	output logic stack_pop,
	output logic discard_next,
	// accumulator and flags
	output logic [7:0] acc,
	output logic zero_flag,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic watchdog_expiry_flag,
	output logic power_down_flag,
	// control side effects
	output logic standby_req,
	output logic watchdog_clear,
	output logic prescaler_clear,
	output logic [7:0] pin_direction,
	output logic [7:0] option_value
);
	// the whole module is built on the package types

	// decode one word; used only for the live word
	function automatic lcbdec_op_t decode(input logic [`LCB_IW-1:0] w);
		logic [3:0] p4;
		p4 = w[`LCB_PFX_MSB:`LCB_PFX_LSB];
		decode = LCB_OP_NOP;
		if (w == `LCB_W_OPTION)
			decode = LCB_OP_OPTION;
		else if (w == `LCB_W_SLEEP)
			decode = LCB_OP_SLEEP;
		else if (w == `LCB_W_WATCHDOG_CLEAR_OP)
			decode = LCB_OP_WATCHDOG_CLEAR_OP;
		else if (w[`LCB_PFX_MSB:`LCB_HI9_LSB] == `LCB_PIN_DIRECTION_LOAD_HI)
			decode = LCB_OP_PIN_DIRECTION_LOAD;
		else if (w[`LCB_PFX_MSB:`LCB_P6_LSB] == `LCB_PFX_ADD)
			decode = LCB_OP_ADD;
		else if (w[`LCB_PFX_MSB:`LCB_P3_LSB] == `LCB_PFX_GOTO)
			decode = LCB_OP_GOTO;
		else
		begin
			case (p4)
				`LCB_PFX_BCLR: decode = LCB_OP_BCLR;
				`LCB_PFX_SKC: decode = LCB_OP_SKC;
				`LCB_PFX_SKS: decode = LCB_OP_SKS;
				`LCB_PFX_RETL: decode = LCB_OP_RETL;
				`LCB_PFX_CALL: decode = LCB_OP_CALL;
				`LCB_PFX_MOVL: decode = LCB_OP_MOVL;
				`LCB_PFX_ORL: decode = LCB_OP_ORL;
				`LCB_PFX_ANDL: decode = LCB_OP_ANDL;
				`LCB_PFX_XORL: decode = LCB_OP_XORL;
				default: decode = LCB_OP_NOP;
			endcase
		end
	endfunction

	// address compare, used for pin source and timer target
	function automatic logic addr_is(input logic [`LCB_FA_MSB:0] a,
		input logic [`LCB_FA_MSB:0] b);
		addr_is = (a == b);
	endfunction

	lcbdec_state_t state_reg; // sequencer state
	lcbdec_state_t state_next; // its next value
	lcbdec_op_t op; // operation executed this cycle
	logic go; // a word is taken this cycle
	logic [`LCB_FA_MSB:0] fa; // register address field
	logic [2:0] bidx; // bit index field
	logic dbit; // destination select
	logic [7:0] lit; // literal field
	logic [7:0] src; // register operand
	logic [7:0] clr_res; // bit clear result
	logic [8:0] sum; // add result with carry
	logic [4:0] nib; // low nibble sum with half carry
	logic tbit; // tested bit
	logic take_skip; // bit test asks to skip
	logic [7:0] lres; // literal logic result
	logic pre_on_timer; // prescaler belongs to the timer

	// register mirrors of the flopped outputs
	logic [7:0] acc_reg;
	logic z_reg;
	logic c_reg;
	logic dc_reg;
	logic to_reg;
	logic pd_reg;
	logic [7:0] dir_reg;
	logic [7:0] opt_reg;
	logic wr_reg;
	logic [`LCB_FA_MSB:0] waddr_reg;
	logic [7:0] wdata_reg;
	logic pcl_reg;
	logic [`LCB_PCW-1:0] pct_reg;
	logic push_reg;
	logic pop_reg;
	logic sby_reg;
	logic wdc_reg;
	logic psc_reg;

	// field split; the read address follows the live word at once
	assign fa = instr[`LCB_FA_MSB:0];
	assign bidx = instr[`LCB_B_MSB:`LCB_B_LSB];
	assign dbit = instr[`LCB_D_BIT];
	assign lit = instr[`LCB_K_MSB:0];
	assign reg_raddr = fa;
	assign go = ce && instr_valid;

	// port reads come from the pins so read-modify-write sees them
	assign src = addr_is(fa, `LCB_ADDR_PORT) ? pin_levels
		: reg_rdata;

	// a discarded word executes as a no-op
	always_comb
	begin
		op = LCB_OP_NOP;
		if (state_reg == LCB_ST_EXEC)
			op = decode(instr);
	end

	// bit clear built one bit at a time
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_clr
			assign clr_res[gi] = (bidx == gi) ? 1'b0
				: src[gi];
		end
	endgenerate

	// adder with carry out of bit 7 and bit 3
	assign sum = {1'b0, acc_reg} + {1'b0, src};
	assign nib = {1'b0, acc_reg[`LCB_NIB_MSB:0]}
		+ {1'b0, src[`LCB_NIB_MSB:0]};

	// bit test outcome
	assign tbit = src[bidx];
	assign take_skip = (op == LCB_OP_SKC && !tbit)
		|| (op == LCB_OP_SKS && tbit);

	// prescaler is on the timer when the assignment bit is low
	assign pre_on_timer = !opt_reg[`LCB_OPT_PSA];

	// literal logic result
	always_comb
	begin
		lres = acc_reg;
		case (op)
			LCB_OP_ANDL: lres = acc_reg & lit;
			LCB_OP_ORL: lres = acc_reg | lit;
			LCB_OP_XORL: lres = acc_reg ^ lit;
			default: lres = acc_reg;
		endcase
	end

	// next sequencer state: skips and branches eat the next word
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			LCB_ST_EXEC:
			begin
				if (take_skip)
					state_next = LCB_ST_FLUSH;
				else if (op == LCB_OP_CALL || op == LCB_OP_GOTO
					|| op == LCB_OP_RETL)
					state_next = LCB_ST_FLUSH;
			end
			LCB_ST_FLUSH: state_next = LCB_ST_EXEC;
			default: state_next = LCB_ST_EXEC;
		endcase
	end

	// sequencer; only advances on a taken word
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			state_reg <= LCB_ST_EXEC;
		else if (go)
			state_reg <= state_next;
	end

	// accumulator
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			acc_reg <= `LCB_RST_ACC;
		else if (go)
		begin
			case (op)
				LCB_OP_ANDL, LCB_OP_ORL, LCB_OP_XORL:
					acc_reg <= lres;
				LCB_OP_MOVL, LCB_OP_RETL:
					acc_reg <= lit;
				LCB_OP_ADD:
					if (!dbit)
						acc_reg <= sum[7:0];
				default: acc_reg <= acc_reg;
			endcase
		end
	end

	// arithmetic flags; bit ops, loads and branches leave them alone
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			z_reg <= 1'b0;
			c_reg <= 1'b0;
			dc_reg <= 1'b0;
		end
		else if (go)
		begin
			case (op)
				LCB_OP_ANDL, LCB_OP_ORL, LCB_OP_XORL:
					z_reg <= (lres == `LCB_ZERO8);
				LCB_OP_ADD:
				begin
					z_reg <= (sum[7:0] == `LCB_ZERO8);
					c_reg <= sum[8];
					dc_reg <= nib[4];
				end
				default: z_reg <= z_reg;
			endcase
		end
	end

	// timeout and power-down status
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			to_reg <= `LCB_RST_TO;
			pd_reg <= `LCB_RST_PD;
		end
		else if (go && op == LCB_OP_WATCHDOG_CLEAR_OP)
		begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end
		else if (go && op == LCB_OP_SLEEP)
		begin
			to_reg <= 1'b1;
			pd_reg <= 1'b0;
		end
	end

	// direction and option latches
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dir_reg <= `LCB_RST_DIR;
			opt_reg <= `LCB_RST_OPT;
		end
		else if (go)
		begin
			// only the port field has latches; other fields do nothing
			if (op == LCB_OP_PIN_DIRECTION_LOAD
				&& instr[`LCB_TF_MSB:0] == `LCB_PIN_DIRECTION_LOAD_PORT)
				dir_reg <= acc_reg;
			if (op == LCB_OP_OPTION)
				opt_reg <= acc_reg;
		end
	end

	// register file write port
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= `LCB_ZERO8;
		end
		else if (ce)
		begin
			wr_reg <= 1'b0;
			if (go && op == LCB_OP_ADD && dbit)
			begin
				wr_reg <= 1'b1;
				waddr_reg <= fa;
				wdata_reg <= sum[7:0];
			end
			else if (go && op == LCB_OP_BCLR)
			begin
				wr_reg <= 1'b1;
				waddr_reg <= fa;
				wdata_reg <= clr_res;
			end
		end
	end

	// program counter and stack requests
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pcl_reg <= 1'b0;
			pct_reg <= '0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
		end
		else if (ce)
		begin
			pcl_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			if (go && op == LCB_OP_GOTO)
			begin
				pcl_reg <= 1'b1;
				pct_reg <= instr[`LCB_PCW-1:0];
			end
			else if (go && op == LCB_OP_CALL)
			begin
				pcl_reg <= 1'b1;
				push_reg <= 1'b1;
				pct_reg <= {1'b0, lit};
			end
			else if (go && op == LCB_OP_RETL)
			begin
				pcl_reg <= 1'b1;
				pop_reg <= 1'b1;
				pct_reg <= {1'b0, ret_addr[`LCB_PC_HI-1:0]};
			end
		end
	end

	// one-cycle side-effect strobes
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sby_reg <= 1'b0;
			wdc_reg <= 1'b0;
			psc_reg <= 1'b0;
		end
		else if (ce)
		begin
			sby_reg <= go && op == LCB_OP_SLEEP;
			wdc_reg <= go && op == LCB_OP_WATCHDOG_CLEAR_OP;
			// writes to the timer restart its prescaler as well, when the assignment bit gives it to the timer
			psc_reg <= go && pre_on_timer
				&& addr_is(fa, `LCB_ADDR_TIMER)
				&& ((op == LCB_OP_ADD && dbit)
				|| op == LCB_OP_BCLR);
		end
	end

	// outputs
	assign acc = acc_reg;
	assign zero_flag = z_reg;
	assign carry_flag = c_reg;
	assign half_carry_flag = dc_reg;
	assign watchdog_expiry_flag = to_reg;
	assign power_down_flag = pd_reg;
	assign pin_direction = dir_reg;
	assign option_value = opt_reg;
	assign reg_wr = wr_reg;
	assign reg_waddr = waddr_reg;
	assign reg_wdata = wdata_reg;
	assign pc_load = pcl_reg;
	assign pc_target = pct_reg;
	assign stack_push = push_reg;
	assign stack_pop = pop_reg;
	assign standby_req = sby_reg;
	assign watchdog_clear = wdc_reg;
	assign prescaler_clear = psc_reg;
	// high while the word now presented will be thrown away
	assign discard_next = (state_reg == LCB_ST_FLUSH);
endmodule
`default_nettype wire

// ===== test/lcbdec_sva.sv
// port assertions for the decoder
`timescale 1ns/100ps
`default_nettype none
module lcbdec_sva (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// instruction stream and operands
	input wire logic ce,
	input wire logic [11:0] instr,
	input wire logic instr_valid,
	input wire logic [4:0] reg_raddr,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pin_levels,
	// results
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic pc_load,
	input wire logic [8:0] pc_target,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic discard_next,
	input wire logic [7:0] acc,
	input wire logic zero_flag,
	input wire logic power_down_flag,
	input wire logic standby_req,
	input wire logic prescaler_clear,
	input wire logic [7:0] pin_direction,
	input wire logic [7:0] option_value
);
	// a word that really executes
	wire tk = ce & instr_valid & ~discard_next;
	// the port reads its pins, never the latch
	wire [7:0] opnd = (reg_raddr == 5'h06) ? pin_levels : reg_rdata;
	wire bsel = opnd[instr[7:5]];
	wire [3:0] pf = instr[11:8];
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_skip_clear: assert property (
		tk && pf == 4'h6 |=> discard_next == !$past(bsel)
		&& $stable(zero_flag)) else $error("skip on clear wrong");
	chk_skip_set: assert property (
		tk && pf == 4'h7 |=> discard_next == $past(bsel)
		&& $stable(zero_flag)) else $error("skip on set wrong");
	chk_discard_once: assert property (
		discard_next && ce && instr_valid |=> !discard_next)
		else $error("discard held too long");
	chk_call_target: assert property (
		tk && pf == 4'h9 |=> pc_load && stack_push && discard_next
		&& pc_target == {1'b0, $past(instr[7:0])})
		else $error("call target wrong");
	chk_return_target: assert property (
		tk && pf == 4'h8 |=> pc_load && stack_pop && discard_next
		&& !pc_target[8]) else $error("return target wrong");
	chk_xor_zero: assert property (
		tk && pf == 4'hF |=> acc == ($past(acc) ^ $past(instr[7:0]))
		&& zero_flag == (acc == 8'h00)) else $error("xor wrong");
	chk_sleep_flags: assert property (
		tk && instr == 12'h003 |=> standby_req && !power_down_flag)
		else $error("standby wrong");
	chk_dir_load: assert property (
		tk && instr == 12'h006 |=> pin_direction == $past(acc))
		else $error("direction load wrong");
	chk_read_addr: assert property (
		reg_raddr == instr[4:0]) else $error("read address wrong");
	chk_add_write: assert property (
		tk && instr[11:5] == 7'h0F |=> reg_wr
		&& reg_wdata == 8'($past(acc) + $past(opnd)))
		else $error("add write wrong");
	chk_bit_clear: assert property (
		tk && pf == 4'h4 |=> reg_wr
		&& reg_wdata == ($past(opnd) & ~(8'h01 << $past(instr[7:5]))))
		else $error("bit clear wrong");
	chk_presc_clear: assert property (
		tk && pf == 4'h4 && instr[4:0] == 5'h01 && !option_value[3]
		|=> prescaler_clear) else $error("prescaler not cleared");

	// main scenarios reached
	cover property (tk && pf == 4'h6 ##1 discard_next);
	cover property (tk && instr == 12'h004);
	cover property (prescaler_clear);
	// a write strobe held through a frozen cycle
	cover property (!ce && reg_wr);
endmodule
`default_nettype wire

// ===== test/lcbdec_core_test.sv
// self-checking bench for the decoder
`timescale 1ns/100ps
`default_nettype none
module lcbdec_core_test;
	// stimulus
	logic clk = 0, resetn = 0, ce = 1, instr_valid = 0;
	logic [11:0] instr = 0;
	logic [7:0] reg_rdata = 0, pin_levels = 0;
	logic [8:0] ret_addr = 0;
	// observed outputs
	logic [4:0] reg_raddr, reg_waddr;
	logic [8:0] pc_target;
	logic reg_wr, pc_load, stack_push, stack_pop, discard_next;
	logic zero_flag, carry_flag, half_carry_flag;
	logic watchdog_expiry_flag, power_down_flag;
	logic standby_req, watchdog_clear, prescaler_clear;
	logic [7:0] reg_wdata, acc, pin_direction, option_value;
	// bookkeeping
	int fail_count = 0, n_tests = 0;
	logic [58:0] q[$];
	logic [58:0] prev; // last note, repeated while the enable is low
	logic [31:0] rs = 32'h433a;
	// reference state
	logic [7:0] m_acc, m_dir, m_opt;
	logic m_z, m_c, m_h, m_d, m_to, m_pd;
	// directed words: option, timer bit clear, load, direction,
	// standby, watchdog, add to port, call, skips, xor, return
	logic [11:0] dw [0:11] = '{12'h002, 12'h421, 12'hC5A, 12'h006,
		12'h003, 12'h004, 12'h1E6, 12'h955, 12'h6E6, 12'h7E6,
		12'hF5A, 12'h822};

	lcbdec_core u_dut (.clk, .resetn, .ce, .instr, .instr_valid,
		.reg_raddr, .reg_rdata, .pin_levels, .reg_wr, .reg_waddr,
		.reg_wdata, .ret_addr, .pc_load, .pc_target, .stack_push,
		.stack_pop, .discard_next, .acc, .zero_flag, .carry_flag,
		.half_carry_flag, .watchdog_expiry_flag, .power_down_flag,
		.standby_req, .watchdog_clear, .prescaler_clear,
		.pin_direction, .option_value);

	// 250 MHz
	always #2 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	task automatic end_of_test;
		$display("tests %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// reference values after reset
	task automatic mreset;
		{m_acc, m_dir, m_opt} = {8'h00, 8'hFF, 8'hFF};
		{m_z, m_c, m_h, m_d, m_to, m_pd} = 6'b000011;
	endtask

	// one edge passes first so the last word is judged before reset
	task automatic do_reset;
		instr_valid <= 0;
		@(posedge clk);
		resetn <= 0;
		mreset();
		repeat (8) @(posedge clk);
		resetn <= 1;
	endtask

	// present one word, note what it must leave behind; with c low the
	// word is not taken and every output, strobes too, must hold
	task automatic op(input logic [11:0] w, input logic [7:0] rd, pl,
		input logic c);
		logic [7:0] v, r;
		logic [8:0] s, pt;
		logic [4:0] wa;
		logic wr, dsc, ld, pu, po, sb, wc, psc;
		wr = 0;
		r = 0;
		pt = 0;
		{ld, pu, po, sb, wc, psc} = 6'h00;
		wa = w[4:0];
		dsc = m_d;
		v = (w[4:0] == 5'h06) ? pl : rd;
		if (c)
			m_d = 0;
		if (c && !dsc)
		begin
			case (w[11:8])
				4'h6: m_d = !v[w[7:5]];
				4'h7: m_d = v[w[7:5]];
				// return target keeps only the low eight stack bits
				4'h8: {m_acc, m_d, ld, po, pt} = {w[7:0], 4'hE,
					rs[7:0]};
				4'h9: {m_d, ld, pu, pt} = {4'hE, w[7:0]};
				4'hA, 4'hB: {m_d, ld, pt} = {2'b11, w[8:0]};
				4'hC: m_acc = w[7:0];
				4'hD: m_acc |= w[7:0];
				4'hE: m_acc &= w[7:0];
				4'hF: m_acc ^= w[7:0];
				4'h4: {wr, r} = {1'b1, v & ~(8'h01 << w[7:5])};
				4'h1: if (w[7:6] == 2'b11)
				begin
					// carries from the full and the low-nibble sums
					s = m_acc + v;
					m_c = s[8];
					m_h = (m_acc[3:0] + v[3:0]) > 5'h0F;
					m_z = s[7:0] == 8'h00;
					if (w[5]) {wr, r} = {1'b1, s[7:0]};
					else m_acc = s[7:0];
				end
				4'h0: if (w[7:3] == 5'h00)
				begin
					case (w[2:0])
						3'h2: m_opt = m_acc;
						3'h3: {m_to, m_pd, sb} = 3'b101;
						3'h4: {m_to, m_pd, wc} = 3'b111;
						3'h6: m_dir = m_acc;
						default: ;
					endcase
				end
				default: ;
			endcase
			// the logic forms refresh the zero flag
			if (w[11:10] == 2'b11 && w[9:8] != 2'b00)
				m_z = m_acc == 8'h00;
			// only timer writes clear a prescaler that the timer owns
			psc = wr && w[4:0] == 5'h01 && !m_opt[3];
		end
		if (c)
			prev = {m_acc, m_z, m_c, m_h, wr, r, m_d, m_to, m_pd, m_dir,
				m_opt, ld, pt, pu, po, sb, wc, psc, wa};
		q.push_back(prev);
		ce <= c;
		instr <= w;
		reg_rdata <= rd;
		pin_levels <= pl;
		ret_addr <= rs[8:0];
		instr_valid <= 1;
		@(posedge clk);
	endtask

	// judge each presented word just after its edge
	always @(posedge clk)
	begin
		logic [58:0] e, a;
		if (instr_valid && resetn)
		begin
			#1;
			e = q.pop_front();
			a = {acc, zero_flag, carry_flag, half_carry_flag, reg_wr,
				reg_wdata, discard_next, watchdog_expiry_flag,
				power_down_flag, pin_direction, option_value, pc_load,
				pc_target, stack_push, stack_pop, standby_req,
				watchdog_clear, prescaler_clear, reg_waddr};
			// write address and data mean nothing without a write,
			// and the branch target nothing without a load
			if (!e[47])
			begin
				a[46:39] = e[46:39];
				a[4:0] = e[4:0];
			end
			if (!e[19])
				a[18:10] = e[18:10];
			n_tests++;
			if (a !== e)
			begin
				fail_count++;
				$display("ERROR t=%0t got %h exp %h", $time, a, e);
			end
		end
	end

	// directed words, random words, then a reset in mid-run
	initial
	begin
		mreset();
		do_reset();
		repeat (2)
		begin
			foreach (dw[i])
				op(dw[i], 8'h3C, 8'h81, 1'b1);
			for (int i = 0; i < 600; i++)
			begin
				rs = xs(rs);
				// about one word in eight meets a low clock enable
				op(rs[11:0], rs[19:12], rs[27:20],
					rs[31:29] != 3'h0);
			end
			do_reset();
		end
		end_of_test();
	end

	// about 1300 cycles expected; cut off at 4000
	initial
	begin
		#(4 * 4000);
		fail_count++;
		end_of_test();
	end
endmodule

bind lcbdec_core lcbdec_sva u_sva (.clk, .resetn, .ce, .instr,
	.instr_valid, .reg_raddr, .reg_rdata, .pin_levels, .reg_wr,
	.reg_wdata, .pc_load, .pc_target, .stack_push, .stack_pop,
	.discard_next,
	.acc, .zero_flag, .power_down_flag, .standby_req,
	.prescaler_clear, .pin_direction, .option_value);
`default_nettype wire
